// >>> hdl/uslm_line_modes.v
// Functional notes
// - IrDA zero bit sent as 3/16 pulse
// - Filter is 8-bit counter preloaded with value
// - Receive falling edge starts per-clock decrement
// - Receive rising edge halts and reloads counter
// - Counter zero drives receiver low one bit
// - Mode 0x1 selects RS485, full behaviour
// - RS485 RTS is inverse of transmitter-empty
// - RS485 RTS stays high through timeguard
// - Mode 0x3 selects modem, asynchronous behaviour
// - Modem mode drives DTR, RTS, watches inputs
// - DTR commands force level; RTS automatic
// - Input level change sets its change flag
// - Reading channel status clears change flags
// - Inactive CTS stops transmitter after character
// - Normal: pin to receiver, transmitter to pin
// - Echo: receive pin copied to transmit pin
// - Local loopback: transmitter to receiver, pin high
// - Remote loopback: receive pin to transmit pin
// - Mode 0x8 selects infrared modulator, demodulator
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/100ps
`include "uslm_defs.vh"

module uslm_line_modes #(
  parameter CD_W = 16
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire rxd,
  input wire cts_n,
  input wire dsr_n,
  input wire dcd_n,
  input wire ri_n,
  output reg txd,
  output reg rts_n,
  output reg dtr_n,
  output reg rcv_in
);

  // ----------------------------------------
  // Local constants
  // ----------------------------------------
  localparam [CD_W-1:0] CD_ONE = 1; // Counter step
  localparam [CD_W-1:0] CD_ZERO = 0; // Divider off
  localparam [1:0] TX_IDLE = 2'h0; // No character
  localparam [1:0] TX_SHIFT = 2'h1; // Shifting a frame
  localparam [1:0] TX_GUARD = 2'h2; // Timeguard idle

  // ----------------------------------------
  // Configuration state
  // ----------------------------------------
  reg [3:0] mode_reg; // Operating mode
  reg [1:0] chmode_reg; // Channel routing
  reg [CD_W-1:0] cd_reg; // Baud divisor
  reg [7:0] tg_reg; // Timeguard in bits
  reg [10:0] fidi_reg; // Clock ratio field
  reg [7:0] ifv_reg; // Infrared filter value
  reg rx_en_reg; // Receiver enabled
  reg tx_en_reg; // Transmitter enabled
  reg rts_cmd_n_reg; // RTS from commands
  reg [3:0] chg_reg; // Change flags
  reg [3:0] lvl_reg; // Last input levels

  // ----------------------------------------
  // Transmitter state
  // ----------------------------------------
  reg [1:0] tx_st_reg; // Transmit state
  reg [9:0] sh_reg; // Frame shifter
  reg [3:0] sub_reg; // Tick within bit
  reg [3:0] bit_reg; // Bit within frame
  reg [7:0] tgc_reg; // Timeguard left
  reg [7:0] thr_reg; // Holding byte
  reg thr_full_reg; // Holding byte valid
  reg [CD_W-1:0] bcnt_reg; // Baud prescaler

  // ----------------------------------------
  // Demodulator state
  // ----------------------------------------
  reg rxd_q_reg; // Previous receive pin
  reg [7:0] fcnt_reg; // Filter counter
  reg frun_reg; // Filter counting
  reg ir_low_reg; // Demodulated zero
  reg [3:0] hcnt_reg; // Low hold ticks

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  // Address map check, used by error and write paths
  function is_mapped;
    input [7:0] a;
    begin
      case (a)
        `USLM_CR_OFF, `USLM_MR_OFF, `USLM_CSR_OFF, `USLM_THR_OFF,
        `USLM_BRGR_OFF, `USLM_TTGR_OFF, `USLM_FIDI_OFF,
        `USLM_IF_OFF: is_mapped = 1'h1;
        default: is_mapped = 1'h0;
      endcase
    end
  endfunction

  // Access phase completes on the edge with pready high
  wire acc = psel & penable & pready;
  wire wr_acc = acc & pwrite & is_mapped(paddr);
  wire rd_acc = acc & ~pwrite;
  wire wr_cr = wr_acc & (paddr == `USLM_CR_OFF);
  wire wr_mr = wr_acc & (paddr == `USLM_MR_OFF);
  wire wr_thr = wr_acc & (paddr == `USLM_THR_OFF);
  wire rd_csr = rd_acc & (paddr == `USLM_CSR_OFF);

  wire is_irda = (mode_reg == `USLM_MODE_IRDA);
  wire is_rs485 = (mode_reg == `USLM_MODE_RS485);
  wire is_modem = (mode_reg == `USLM_MODE_MODEM);

  // Baud enable: CD master clocks per oversample tick
  wire tick = (cd_reg != CD_ZERO) && (bcnt_reg == cd_reg - CD_ONE);
  wire bit_end = tick && (sub_reg == `USLM_OVS_LAST);

  // Empty means nothing held, shifting or guarding
  wire tx_empty = (tx_st_reg == TX_IDLE) && !thr_full_reg;
  // Remote loopback silences the transmitter; CTS gates starts only
  wire tx_allow = tx_en_reg && (chmode_reg != `USLM_CH_REMOTE) &&
                  !(is_modem && cts_n);
  wire tx_raw = (tx_st_reg == TX_SHIFT) ? sh_reg[0] : 1'h1;
  // Light pulse in the first three of sixteen ticks of a zero
  wire ir_pulse = (tx_st_reg == TX_SHIFT) && !sh_reg[0] &&
                  (sub_reg < `USLM_IR_PULSE);

  // Current input levels, same order as the flags
  wire [3:0] lvl_now = {cts_n, dcd_n, dsr_n, ri_n};

  // Status word for reads
  wire [31:0] csr_word = {8'h00, lvl_reg, chg_reg, 6'h00,
                          tx_empty, 7'h00, !thr_full_reg, 1'h0};

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // No wait state: data prepared in setup, pready in the first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'h0;
      pslverr <= 1'h0;
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pready) begin
      pready <= 1'h1;
      pslverr <= !is_mapped(paddr);
      // Write-only and unmapped words read as zero
      case (paddr)
        `USLM_MR_OFF: prdata <= {16'h0000, chmode_reg, 10'h000, mode_reg};
        `USLM_CSR_OFF: prdata <= csr_word;
        `USLM_BRGR_OFF: prdata <= {{(32-CD_W){1'h0}}, cd_reg};
        `USLM_TTGR_OFF: prdata <= {24'h000000, tg_reg};
        `USLM_FIDI_OFF: prdata <= {21'h000000, fidi_reg};
        `USLM_IF_OFF: prdata <= {24'h000000, ifv_reg};
        default: prdata <= 32'h00000000;
      endcase
    end else begin
      pready <= 1'h0;
      pslverr <= 1'h0;
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  // Writes land only at the completing access edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= `USLM_MODE_NORMAL;
      chmode_reg <= `USLM_CH_NORMAL;
      cd_reg <= CD_ZERO;
      tg_reg <= 8'h00;
      fidi_reg <= `USLM_FIDI_RESET;
      ifv_reg <= 8'h00;
    end else if (wr_acc) begin
      if (wr_mr) begin
        mode_reg <= pwdata[`USLM_MR_MODE_MSB:`USLM_MR_MODE_LSB];
        chmode_reg <= pwdata[`USLM_MR_CH_MSB:`USLM_MR_CH_LSB];
      end
      if (paddr == `USLM_BRGR_OFF) begin
        cd_reg <= pwdata[CD_W-1:0];
      end
      if (paddr == `USLM_TTGR_OFF) begin
        tg_reg <= pwdata[7:0];
      end
      // Ratio field is only stored and read back; the infrared path does not use it
      if (paddr == `USLM_FIDI_OFF) begin
        fidi_reg <= pwdata[10:0];
      end
      if (paddr == `USLM_IF_OFF) begin
        ifv_reg <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------
  // Control commands
  // ----------------------------------------
  // Disable or release wins when both halves of a pair are written
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_en_reg <= 1'h0;
      tx_en_reg <= 1'h0;
      dtr_n <= 1'h1;
      rts_cmd_n_reg <= 1'h1;
    end else if (wr_cr) begin
      if (pwdata[`USLM_CR_RXDIS]) begin
        rx_en_reg <= 1'h0;
      end else if (pwdata[`USLM_CR_RXEN]) begin
        rx_en_reg <= 1'h1;
      end
      if (pwdata[`USLM_CR_TXDIS]) begin
        tx_en_reg <= 1'h0;
      end else if (pwdata[`USLM_CR_TXEN]) begin
        tx_en_reg <= 1'h1;
      end
      // Release drives high, assert drives low
      if (pwdata[`USLM_CR_DTR_RELEASE]) begin
        dtr_n <= 1'h1;
      end else if (pwdata[`USLM_CR_DTR_ASSERT]) begin
        dtr_n <= 1'h0;
      end
      if (pwdata[`USLM_CR_RTS_RELEASE]) begin
        rts_cmd_n_reg <= 1'h1;
      end else if (pwdata[`USLM_CR_RTS_ASSERT]) begin
        rts_cmd_n_reg <= 1'h0;
      end
    end
  end

  // ----------------------------------------
  // Modem input change flags
  // ----------------------------------------
  // A change seen during the clearing read survives it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_reg <= 4'hF;
      chg_reg <= 4'h0;
    end else begin
      lvl_reg <= lvl_now;
      chg_reg <= (rd_csr ? 4'h0 : chg_reg) |
                 (is_modem ? (lvl_reg ^ lvl_now) : 4'h0);
    end
  end

  // ----------------------------------------
  // Baud prescaler
  // ----------------------------------------
  // Divisor of zero stops all bit timing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bcnt_reg <= CD_ZERO;
    end else if (tick || cd_reg == CD_ZERO) begin
      bcnt_reg <= CD_ZERO;
    end else begin
      bcnt_reg <= bcnt_reg + CD_ONE;
    end
  end

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  // 8N1 frame, LSB first, sixteen ticks per bit
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_reg <= TX_IDLE;
      sh_reg <= 10'h3FF;
      sub_reg <= 4'h0;
      bit_reg <= 4'h0;
      tgc_reg <= 8'h00;
      thr_reg <= 8'h00;
      thr_full_reg <= 1'h0;
    end else begin
      if (tick) begin
        sub_reg <= sub_reg + 4'h1;
      end
      case (tx_st_reg)
        TX_IDLE: begin
          // CTS only blocks a new start, never a frame in flight
          if (thr_full_reg && tx_allow) begin
            sh_reg <= {1'h1, thr_reg, 1'h0};
            tx_st_reg <= TX_SHIFT;
            sub_reg <= 4'h0;
            bit_reg <= 4'h0;
          end
        end
        TX_SHIFT: begin
          if (bit_end) begin
            if (bit_reg == `USLM_FRAME_LAST) begin
              // Guard keeps the empty flag low, so RTS stays up
              if (tg_reg != 8'h00) begin
                tx_st_reg <= TX_GUARD;
                tgc_reg <= tg_reg;
              end else begin
                tx_st_reg <= TX_IDLE;
              end
            end else begin
              bit_reg <= bit_reg + 4'h1;
              sh_reg <= {1'h1, sh_reg[9:1]};
            end
          end
        end
        TX_GUARD: begin
          if (bit_end) begin
            tgc_reg <= tgc_reg - 8'h01;
            if (tgc_reg == 8'h01) begin
              tx_st_reg <= TX_IDLE;
            end
          end
        end
        default: begin
          tx_st_reg <= TX_IDLE;
        end
      endcase
      // A fresh write keeps the full flag set while the old byte moves to the shifter
      if (wr_thr) begin
        thr_reg <= pwdata[7:0];
        thr_full_reg <= 1'h1;
      end else if (tx_st_reg == TX_IDLE && thr_full_reg && tx_allow) begin
        thr_full_reg <= 1'h0;
      end
    end
  end

  // ----------------------------------------
  // Infrared demodulator filter
  // ----------------------------------------
  // Pulses shorter than the filter value plus two clocks are glitches
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_q_reg <= 1'h1;
      fcnt_reg <= 8'h00;
      frun_reg <= 1'h0;
      ir_low_reg <= 1'h0;
      hcnt_reg <= 4'h0;
    end else begin
      rxd_q_reg <= rxd;
      if (rxd_q_reg && !rxd) begin
        frun_reg <= is_irda;
        fcnt_reg <= ifv_reg;
      end else if (!rxd_q_reg && rxd) begin
        frun_reg <= 1'h0;
        fcnt_reg <= ifv_reg;
      end else if (!frun_reg) begin
        fcnt_reg <= ifv_reg;
      end else if (fcnt_reg == 8'h00) begin
        frun_reg <= 1'h0;
        fcnt_reg <= ifv_reg;
        ir_low_reg <= 1'h1;
        hcnt_reg <= 4'h0;
      end else begin
        fcnt_reg <= fcnt_reg - 8'h01;
      end
      // Receiver sees low for sixteen ticks, one bit time
      if (ir_low_reg && tick) begin
        hcnt_reg <= hcnt_reg + 4'h1;
        if (hcnt_reg == `USLM_OVS_LAST) begin
          ir_low_reg <= 1'h0;
        end
      end
    end
  end

  // ----------------------------------------
  // Pin routing and line control
  // ----------------------------------------
  // All pins registered: one clock of latency on each path
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd <= 1'h1;
      rcv_in <= 1'h1;
      rts_n <= 1'h1;
    end else begin
      case (chmode_reg)
        `USLM_CH_NORMAL: begin
          txd <= is_irda ? ir_pulse : tx_raw;
          rcv_in <= is_irda ? !ir_low_reg : rxd;
        end
        `USLM_CH_ECHO: begin
          txd <= rxd;
          rcv_in <= is_irda ? !ir_low_reg : rxd;
        end
        `USLM_CH_LOCAL: begin
          txd <= 1'h1;
          rcv_in <= tx_raw;
        end
        default: begin
          txd <= rxd;
          rcv_in <= 1'h1;
        end
      endcase
      // RS485 keys the driver; modem follows receiver enable
      if (is_rs485) begin
        rts_n <= !tx_empty;
      end else if (is_modem) begin
        rts_n <= !rx_en_reg;
      end else begin
        rts_n <= rts_cmd_n_reg;
      end
    end
  end

endmodule

// >>> common/uslm_defs.vh
`ifndef USLM_DEFS_VH
`define USLM_DEFS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define USLM_CR_OFF 8'h00
`define USLM_MR_OFF 8'h04
`define USLM_CSR_OFF 8'h14
`define USLM_THR_OFF 8'h1C
`define USLM_BRGR_OFF 8'h20
`define USLM_TTGR_OFF 8'h28
`define USLM_FIDI_OFF 8'h40
`define USLM_IF_OFF 8'h4C
// ----------------------------------------
// Operating modes
// ----------------------------------------
`define USLM_MODE_NORMAL 4'h0
`define USLM_MODE_RS485 4'h1
`define USLM_MODE_MODEM 4'h3
`define USLM_MODE_IRDA 4'h8
// ----------------------------------------
// Channel modes
// ----------------------------------------
`define USLM_CH_NORMAL 2'h0
`define USLM_CH_ECHO 2'h1
`define USLM_CH_LOCAL 2'h2
`define USLM_CH_REMOTE 2'h3
// ----------------------------------------
// Field positions
// ----------------------------------------
`define USLM_MR_MODE_MSB 3
`define USLM_MR_MODE_LSB 0
`define USLM_MR_CH_MSB 15
`define USLM_MR_CH_LSB 14
`define USLM_CR_RXEN 4
`define USLM_CR_RXDIS 5
`define USLM_CR_TXEN 6
`define USLM_CR_TXDIS 7
`define USLM_CR_DTR_ASSERT 16
`define USLM_CR_DTR_RELEASE 17
`define USLM_CR_RTS_ASSERT 18
`define USLM_CR_RTS_RELEASE 19
// ----------------------------------------
// Reset values and timing counts
// ----------------------------------------
`define USLM_FIDI_RESET 11'h174
`define USLM_OVS_LAST 4'hF
`define USLM_IR_PULSE 4'h3
`define USLM_FRAME_LAST 4'h9
`endif

// >>> tb/uslm_line_partner.sv
`timescale 1ns/100ps
// ----------------------------------------
// Line partner: transceiver and modem
// ----------------------------------------
module uslm_line_partner (
  input wire pclk,
  input wire rx_lvl,
  input wire [3:0] mdm_lvl,
  input wire [7:0] pulse_len,
  input wire pulse_go,
  output reg rxd,
  output wire ri_n,
  output wire dsr_n,
  output wire dcd_n,
  output wire cts_n
);
  reg [7:0] cnt = 8'h00; // Low cycles left in a light pulse
  initial rxd = 1'b1;
  assign {cts_n, dcd_n, dsr_n, ri_n} = mdm_lvl; // Modem lines as commanded
  // A light pulse pulls the receive line low for pulse_len cycles
  always @(posedge pclk) begin
    if (pulse_go)
      cnt <= pulse_len - 8'h01;
    else if (cnt != 8'h00)
      cnt <= cnt - 8'h01;
    rxd <= rx_lvl & (cnt == 8'h00) & !pulse_go;
  end
endmodule

// >>> tb/uslm_line_modes_properties.sv
`timescale 1ns/100ps
module uslm_line_modes_properties #(
  parameter CD_W = 16
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire rxd,
  input wire cts_n,
  input wire dsr_n,
  input wire dcd_n,
  input wire ri_n,
  input wire txd,
  input wire rts_n,
  input wire dtr_n,
  input wire rcv_in
);
  reg [3:0] mode_q; // Operating mode as written
  reg [1:0] ch_q; // Channel mode as written
  wire acc = psel && penable && pready && pwrite; // A write lands here
  wire cr_wr = acc && paddr == 8'h00;
  // Shadow of the mode register, updated at the access edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 4'h0;
      ch_q <= 2'h0;
    end else if (acc && paddr == 8'h04) begin
      mode_q <= pwdata[3:0];
      ch_q <= pwdata[15:14];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_setup_answer: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  chk_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  chk_unmapped_err: assert property (pready && !(paddr inside {8'h00, 8'h04, 8'h14,
    8'h1C, 8'h20, 8'h28, 8'h40, 8'h4C}) |-> pslverr) else $error("no error on hole");
  chk_dtr_low: assert property (cr_wr && pwdata[16] && !pwdata[17] |=> !dtr_n)
    else $error("dtr not driven low");
  chk_dtr_high: assert property (cr_wr && pwdata[17] |=> dtr_n)
    else $error("dtr not driven high");
  chk_normal_route: assert property (
    (ch_q == 2'h0 && mode_q != 4'h8 && $stable(rxd)) [*3] |-> rcv_in == rxd)
    else $error("normal receive path wrong");
  chk_echo_route: assert property ((ch_q == 2'h1 && $stable(rxd)) [*3] |-> txd == rxd)
    else $error("echo path wrong");
  chk_local_idle: assert property ((ch_q == 2'h2) [*3] |-> txd)
    else $error("local loop pin not high");
  chk_remote_route: assert property ((ch_q == 2'h3 && $stable(rxd)) [*3]
    |-> txd == rxd && rcv_in) else $error("remote loop path wrong");
endmodule
bind uslm_line_modes uslm_line_modes_properties #(.CD_W(CD_W)) i_props (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
  .cts_n(cts_n), .dsr_n(dsr_n), .dcd_n(dcd_n), .ri_n(ri_n), .txd(txd), .rts_n(rts_n),
  .dtr_n(dtr_n), .rcv_in(rcv_in));

// >>> tb/uslm_line_modes_tb_top.sv
`timescale 1ns/100ps
module uslm_line_modes_tb_top;
  reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg [7:0] paddr = 8'h00, plen = 8'h00;
  reg [31:0] pwdata = 32'h0, rd;
  reg rx_lvl = 1'b1, pulse_go = 1'b0, err;
  reg [3:0] mdm = 4'hF; // Modem lines idle inactive
  wire [31:0] prdata;
  wire pready, pslverr, rxd, cts_n, dsr_n, dcd_n, ri_n, txd, rts_n, dtr_n, rcv_in;
  integer miscompares = 0, checks_done = 0, cyc = 0, i, n;
  uslm_line_modes i_uslm_line_modes (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd(rxd), .cts_n(cts_n), .dsr_n(dsr_n),
    .dcd_n(dcd_n), .ri_n(ri_n), .txd(txd), .rts_n(rts_n), .dtr_n(dtr_n), .rcv_in(rcv_in));
  uslm_line_partner i_uslm_line_partner (.pclk(pclk), .rx_lvl(rx_lvl), .mdm_lvl(mdm),
    .pulse_len(plen), .pulse_go(pulse_go), .rxd(rxd), .ri_n(ri_n), .dsr_n(dsr_n),
    .dcd_n(dcd_n), .cts_n(cts_n));
  initial forever #5 pclk = ~pclk;
  // Hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      final_report;
    end
  end
  task check(input [31:0] seen, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // One APB transfer; a spare edge keeps strobes from toggling twice in a step
  task apb(input wr, input [7:0] a, input [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // Only the hang guard ends a wait for the answer
      while (pready !== 1'b1) begin
        @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task wait_tx(input v);
    begin
      n = 0;
      while (txd !== v) begin
        n = n + 1;
        @(posedge pclk);
      end
    end
  endtask
  // Sample one frame mid-bit; CTS is lifted once the start bit shows
  task frame(input [7:0] d, input r);
    begin
      wait_tx(1'b0);
      mdm <= 4'h8;
      repeat (8) @(posedge pclk);
      for (i = 0; i < 10; i = i + 1) begin
        check(txd, ({1'b1, d, 1'b0} >> i) & 10'h1);
        check(rts_n, r);
        repeat (16) @(posedge pclk);
      end
    end
  endtask
  // Light pulse in, count receiver-low cycles
  task pulse(input [7:0] l);
    begin
      plen <= l;
      pulse_go <= 1'b1;
      @(posedge pclk);
      pulse_go <= 1'b0;
      n = 0;
      repeat (40) begin
        @(posedge pclk);
        n = n + !rcv_in;
      end
    end
  endtask
  task final_report;
    begin
      $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check({txd, rcv_in, rts_n, dtr_n}, 4'hF);
    apb(0, 8'h40, 0);
    check(rd, 32'h174);
    apb(0, 8'h04, 0);
    check(rd, 32'h0);
    apb(0, 8'h2C, 0);
    check(err, 1'b1);
    $display("end test reset");
    apb(1, 8'h00, 32'h10000);
    check(dtr_n, 1'b0);
    apb(1, 8'h00, 32'h20000);
    check(dtr_n, 1'b1);
    apb(1, 8'h04, 32'h3);
    apb(1, 8'h00, 32'h50);
    // Receiver enable lands first, the pin follows one edge later
    @(posedge pclk);
    check(rts_n, 1'b0);
    mdm <= 4'h0;
    repeat (4) @(posedge pclk);
    apb(0, 8'h14, 0);
    check(rd & 32'hF0000, 32'hF0000);
    apb(0, 8'h14, 0);
    check(rd & 32'hF0000, 32'h0);
    $display("end test modem lines");
    apb(1, 8'h20, 32'h1); // Divisor 1 keeps the rate error at zero
    mdm <= 4'h8;
    apb(1, 8'h1C, 32'hA5);
    repeat (40) @(posedge pclk);
    check(txd, 1'b1);
    mdm <= 4'h0;
    frame(8'hA5, 1'b0);
    $display("end test clear to send");
    apb(1, 8'h04, 32'h1);
    apb(1, 8'h28, 32'h2);
    apb(1, 8'h1C, 32'h3C);
    frame(8'h3C, 1'b1);
    check(rts_n, 1'b1);
    repeat (40) @(posedge pclk);
    check(rts_n, 1'b0);
    $display("end test line driver");
    apb(1, 8'h04, 32'h8); // Ratio field stays at its nonzero reset value
    apb(1, 8'h4C, 32'h4);
    apb(1, 8'h1C, 32'hFE);
    wait_tx(1'b1);
    wait_tx(1'b0);
    check(n, 3);
    pulse(8'h04);
    check(n, 0);
    pulse(8'h08);
    check(n, 16);
    pulse(8'h04);
    check(n, 0);
    $display("end test infrared");
    repeat (100) @(posedge pclk);
    for (i = 0; i < 4; i = i + 1) begin
      apb(1, 8'h04, i << 14);
      rx_lvl <= 1'b0;
      repeat (4) @(posedge pclk);
      check({txd, rcv_in}, (8'h72 >> (2 * i)) & 8'h3);
      rx_lvl <= 1'b1;
      repeat (4) @(posedge pclk);
    end
    // Remote loopback must leave a held byte untouched
    apb(1, 8'h1C, 32'h00);
    repeat (40) @(posedge pclk);
    apb(0, 8'h14, 0);
    check(rd & 32'h2, 32'h0);
    $display("end test channel modes");
    // Outside modem and line-driver modes RTS follows its commands
    apb(1, 8'h00, 32'h40000);
    @(posedge pclk);
    check(rts_n, 1'b0);
    apb(1, 8'h00, 32'hC0000);
    @(posedge pclk);
    check(rts_n, 1'b1);
    $display("end test rts commands");
    final_report;
  end
endmodule
